// >>> src/hub_cfg_pkg.sv
// package: register map, field positions, reset values and timing for the interlock block
`default_nettype none
package hub_cfg_pkg;
  // register offsets on the serial configuration port
  localparam logic [7:0] ADDR_INTERLOCK = 8'he7;
  localparam logic [7:0] ADDR_STATUS = 8'he8;
  localparam logic [7:0] ADDR_MASK = 8'he9;
  // interlock field positions
  localparam int OCS_SEL_BIT = 5;
  localparam int PWR_SEL_BIT = 4;
  localparam int HOLD_CONN_BIT = 1;
  localparam int HOLD_CFG_BIT = 0;
  localparam logic [7:0] INTERLOCK_RESET = 8'h32;
  localparam logic [7:0] INTERLOCK_WMASK = 8'h33;
  // status field positions
  localparam int INT_ACTIVE_BIT = 7;
  localparam int SUSP_BIT = 4;
  localparam int CFGD_BIT = 3;
  localparam int PWR_UPD_BIT = 2;
  localparam logic [7:0] EVENT_MASK = 8'h1c;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [7:0] MASK_RESET = 8'h00;
  // configuration timeout
  localparam int CLK_PERIOD_NS = 10;
  localparam int CFG_TIMEOUT_MS = 95;
  localparam int CFG_TIMEOUT_CYCLES = (CFG_TIMEOUT_MS * 1000000) / CLK_PERIOD_NS;
  // hub stages, gray coded along the usual path
  typedef enum logic [1:0] {
    STAGE_CONFIG = 2'b00,
    STAGE_CONNECT = 2'b01,
    STAGE_COMM = 2'b11
  } hub_stage_t;
endpackage
`default_nettype wire

// >>> src/cfg_timeout.sv
// configuration timeout counter that flags expiry once
`default_nettype none
module cfg_timeout #(
  parameter int unsigned COUNT = 32'd9500000
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic run,
  output logic expired
);
  localparam int W = $clog2(COUNT + 1);
  logic [W-1:0] cnt_q, cnt_d;
  logic exp_q, exp_d;

  // count while running, latch expiry
  always_comb begin
    cnt_d = cnt_q;
    exp_d = exp_q;
    if (run && !exp_q) begin
      if (cnt_q == W'(COUNT - 1)) begin
        exp_d = 1'b1;
      end else begin
        cnt_d = cnt_q + W'(1);
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cnt_q <= '0;
      exp_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      exp_q <= exp_d;
    end
  end

  assign expired = exp_q;
endmodule
`default_nettype wire

// >>> src/hub_config_interlock_irq.sv
// interlock control, event status and interrupt pin of the hub configuration port
//
// Function
// R1: overcurrent select one uses active-low sense pin, else register over-current bit.
// R2: power switch select one drives port power pin high-active, else pin disabled.
// R3: hold-connect one keeps hub in connect stage until cleared.
// R4: hold-connect zero lets hub advance from connect to communication stage.
// R5: hold-configuration one keeps configuration stage and accepts register writes.
// R6: writing hold-configuration zero leaves configuration stage at once.
// R7: with no write, configuration stage ends only after timeout expires.
// R8: host should write interlock register first, within the timeout.
// R9: host must clear hold-configuration after writing its configuration.
// R10: interlock resets to 0x32: both pins enabled, hold-connect set.
// R11: status top bit reads one while interrupt pin low from unmasked event.
// R12: writing zero to top status bit releases pin; one has no effect.
// R13: suspend flag sets on suspend entry, clears by writing zero.
// R14: host-configured flag sets on configuration, clears by writing zero.
// R15: port-power-update flag sets on update, clears by writing zero.
// R16: event drives interrupt pin low only when its mask bit is one.
// R17: default configuration timeout is about 95 ms.
// R18: reserved bits read zero and ignore writes.
`default_nettype none
module hub_config_interlock_irq
  import hub_cfg_pkg::*;
#(
  parameter int unsigned CFG_TIMEOUT = hub_cfg_pkg::CFG_TIMEOUT_CYCLES
) (
  input wire logic ref_clk,
  input wire logic rst,
  // register port from the serial slave
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // hub events, one-cycle pulses from hub logic
  input wire logic suspend_event,
  input wire logic host_configured_event,
  input wire logic port_power_event,
  // register-side over-current and port power control
  input wire logic overcurrent_reg,
  input wire logic port_power_reg,
  // pins
  input wire logic overcurrent_sense_pin_n,
  output logic port_power_pin,
  output logic port_power_pin_oe,
  output logic int_pin_n,
  // resolved state toward the hub
  output logic overcurrent,
  output logic [1:0] hub_stage,
  output logic config_writes_open
);
  import hub_cfg_pkg::*;

  // ----------------------------------------
  // pin synchroniser
  // ----------------------------------------
  logic ocs_meta_q, ocs_sync_q;

  // two flops before anything reads the sense pin
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ocs_meta_q <= 1'b1;
      ocs_sync_q <= 1'b1;
    end else begin
      ocs_meta_q <= overcurrent_sense_pin_n;
      ocs_sync_q <= ocs_meta_q;
    end
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [7:0] ilock_q, ilock_d;
  logic [7:0] status_q, status_d;
  logic [7:0] mask_q, mask_d;
  logic wr_ilock, wr_status, wr_mask;
  logic [7:0] ev_vec;
  logic int_set;

  assign wr_ilock = reg_wr && (reg_addr == ADDR_INTERLOCK);
  assign wr_status = reg_wr && (reg_addr == ADDR_STATUS);
  assign wr_mask = reg_wr && (reg_addr == ADDR_MASK);

  // gather event pulses at their flag positions
  always_comb begin
    ev_vec = 8'h00;
    ev_vec[SUSP_BIT] = suspend_event;
    ev_vec[CFGD_BIT] = host_configured_event;
    ev_vec[PWR_UPD_BIT] = port_power_event;
  end

  // an unmasked event pulls the pin
  assign int_set = |(ev_vec & mask_q & EVENT_MASK); // R16

  // next register values; set wins over a same-cycle clear
  always_comb begin
    ilock_d = ilock_q;
    mask_d = mask_q;
    status_d = status_q;
    if (wr_ilock) begin
      ilock_d = reg_wdata & INTERLOCK_WMASK; // R18
    end
    if (wr_mask) begin
      mask_d = reg_wdata & EVENT_MASK; // R18
    end
    if (wr_status) begin
      // zero clears, one keeps
      status_d = status_q & (reg_wdata | ~(EVENT_MASK | 8'h80)); // R12 R13 R14 R15
    end
    status_d = status_d | ev_vec; // R13 R14 R15
    if (int_set) begin
      status_d[INT_ACTIVE_BIT] = 1'b1; // R11
    end
    status_d = status_d & (EVENT_MASK | 8'h80); // R18
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ilock_q <= INTERLOCK_RESET; // R10
      status_q <= STATUS_RESET;
      mask_q <= MASK_RESET;
    end else begin
      ilock_q <= ilock_d;
      status_q <= status_d;
      mask_q <= mask_d;
    end
  end

  // ----------------------------------------
  // hub stage sequencing
  // ----------------------------------------
  hub_stage_t stage_q, stage_d;
  logic cfg_written_q, cfg_written_d;
  logic tout_expired;

  // timeout runs only while nobody has touched the interlock
  cfg_timeout #(
    .COUNT(CFG_TIMEOUT)
  ) u_timeout (
    .ref_clk(ref_clk),
    .rst(rst),
    .run(stage_q == STAGE_CONFIG && !cfg_written_q),
    .expired(tout_expired)
  ); // R17

  // stage transitions
  always_comb begin
    stage_d = stage_q;
    cfg_written_d = cfg_written_q | wr_ilock;
    unique case (stage_q)
      STAGE_CONFIG: begin
        if (wr_ilock && !reg_wdata[HOLD_CFG_BIT]) begin
          stage_d = STAGE_CONNECT; // R6
        end else if (!cfg_written_q && !ilock_q[HOLD_CFG_BIT] && tout_expired) begin
          stage_d = STAGE_CONNECT; // R7
        end
        // held while hold-configuration is set // R5
      end
      STAGE_CONNECT: begin
        if (!ilock_q[HOLD_CONN_BIT]) begin
          stage_d = STAGE_COMM; // R4
        end
        // otherwise held indefinitely // R3
      end
      STAGE_COMM: begin
        stage_d = STAGE_COMM;
      end
      default: begin
        stage_d = STAGE_CONFIG;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      stage_q <= STAGE_CONFIG;
      cfg_written_q <= 1'b0;
    end else begin
      stage_q <= stage_d;
      cfg_written_q <= cfg_written_d;
    end
  end

  // ----------------------------------------
  // registered outputs
  // ----------------------------------------
  logic [7:0] rdata_q, rdata_d;
  logic pwr_q, pwr_d, pwr_oe_q, pwr_oe_d, oc_q, oc_d, int_n_q, int_n_d;
  logic [1:0] stage_out_q;
  logic open_q;

  // read mux, pin muxes and interrupt pin
  always_comb begin
    rdata_d = rdata_q;
    if (reg_rd) begin
      unique case (reg_addr)
        ADDR_INTERLOCK: rdata_d = ilock_q;
        ADDR_STATUS: rdata_d = status_q;
        ADDR_MASK: rdata_d = mask_q;
        default: rdata_d = 8'h00;
      endcase
    end
    oc_d = ilock_q[OCS_SEL_BIT] ? !ocs_sync_q : overcurrent_reg; // R1
    pwr_oe_d = ilock_q[PWR_SEL_BIT]; // R2
    pwr_d = ilock_q[PWR_SEL_BIT] && port_power_reg; // R2
    int_n_d = !status_d[INT_ACTIVE_BIT]; // R11 R12
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rdata_q <= 8'h00;
      oc_q <= 1'b0;
      pwr_q <= 1'b0;
      pwr_oe_q <= 1'b0;
      int_n_q <= 1'b1;
      stage_out_q <= STAGE_CONFIG;
      open_q <= 1'b1;
    end else begin
      rdata_q <= rdata_d;
      oc_q <= oc_d;
      pwr_q <= pwr_d;
      pwr_oe_q <= pwr_oe_d;
      int_n_q <= int_n_d;
      stage_out_q <= stage_d;
      open_q <= (stage_d == STAGE_CONFIG); // R5
    end
  end

  assign reg_rdata = rdata_q;
  assign overcurrent = oc_q;
  assign port_power_pin = pwr_q;
  assign port_power_pin_oe = pwr_oe_q;
  assign int_pin_n = int_n_q;
  assign hub_stage = stage_out_q;
  assign config_writes_open = open_q;
endmodule
`default_nettype wire

// >>> sim/host_model.sv
// host processor model on the serial register port
`default_nettype none
module host_model (
  input wire logic ref_clk,
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  // idle port at time zero
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end
  // one-cycle write; caller writes interlock first, hold cleared last
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    reg_wdata <= ~d; // released data must not look valid
  endtask
  // one-cycle read, data taken after the strobe edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
endmodule
`default_nettype wire

// >>> sim/hub_cfg_assertions.sv
// port checks for the interlock block
`default_nettype none
module hub_cfg_checker (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic suspend_event,
  input wire logic host_configured_event,
  input wire logic port_power_event,
  input wire logic port_power_pin,
  input wire logic port_power_pin_oe,
  input wire logic int_pin_n,
  input wire logic [1:0] hub_stage,
  input wire logic config_writes_open
);
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  logic evt;
  logic clr;
  // any event, and a status write clearing the top bit
  assign evt = suspend_event | host_configured_event | port_power_event;
  assign clr = reg_wr && reg_addr == 8'he8 && !reg_wdata[7];
  a_int_release: assert property (clr && !evt |=> int_pin_n)
    else $error("int not released");
  a_int_hold: assert property (!int_pin_n && !clr |=> !int_pin_n)
    else $error("int dropped");
  a_int_cause: assert property (int_pin_n && !evt |=> int_pin_n)
    else $error("int without event");
  a_comm_stays: assert property (hub_stage == 2'b11 |=> hub_stage == 2'b11)
    else $error("left comm");
  a_cfg_open: assert property (config_writes_open == (hub_stage == 2'b00))
    else $error("open mismatch");
  a_cfg_hold: assert property (reg_wr && reg_addr == 8'he7 && reg_wdata[0] && hub_stage == 2'b00
    |=> hub_stage == 2'b00 && config_writes_open)
    else $error("config not held");
  a_cfg_leave: assert property (reg_wr && reg_addr == 8'he7 && !reg_wdata[0] && hub_stage == 2'b00
    |=> hub_stage == 2'b01)
    else $error("config not left");
  a_pin_off: assert property (!port_power_pin_oe |-> !port_power_pin)
    else $error("pin driven");
  a_rsvd_zero: assert property (reg_rd && reg_addr == 8'he7 |=> (reg_rdata & 8'hcc) == 8'h00)
    else $error("reserved set");
endmodule
`default_nettype wire

// >>> sim/hub_config_interlock_irq_bench.sv
// self-checking bench for the interlock block
`default_nettype none
module hub_config_interlock_irq_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic reg_wr, reg_rd, port_power_pin, port_power_pin_oe, int_pin_n, overcurrent, config_writes_open;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, rv;
  logic [1:0] hub_stage;
  logic suspend_event = 1'b0, host_configured_event = 1'b0, port_power_event = 1'b0;
  logic overcurrent_reg = 1'b0, port_power_reg = 1'b1, overcurrent_sense_pin_n = 1'b1;
  int n_mismatch = 0, num_checks = 0;
  // 100 MHz clock
  always #5 ref_clk = ~ref_clk;
  hub_config_interlock_irq #(.CFG_TIMEOUT(20)) hub_config_interlock_irq_i (.ref_clk, .rst, .reg_wr, .reg_rd,
    .reg_addr, .reg_wdata, .reg_rdata, .suspend_event, .host_configured_event, .port_power_event,
    .overcurrent_reg, .port_power_reg, .overcurrent_sense_pin_n, .port_power_pin, .port_power_pin_oe,
    .int_pin_n, .overcurrent, .hub_stage, .config_writes_open);
  host_model host_model_i (.ref_clk, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata);
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic step();
    @(posedge ref_clk);
    #1;
  endtask
  task automatic w(input logic [7:0] a, input logic [7:0] d);
    host_model_i.wr(a, d);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    host_model_i.rd(a, rv);
    chk("rdata", exp, rv);
  endtask
  task automatic do_reset();
    @(posedge ref_clk) rst <= 1'b1;
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    step();
  endtask
  task automatic pulse(input int k);
    @(posedge ref_clk);
    suspend_event <= (k == 4);
    host_configured_event <= (k == 3);
    port_power_event <= (k == 2);
    @(posedge ref_clk);
    {suspend_event, host_configured_event, port_power_event} <= 3'b000;
    step();
  endtask
  task automatic t_defaults();
    do_reset();
    chk("stage", 8'h00, {6'h0, hub_stage});
    chk("oe", 8'h01, {7'h0, port_power_pin_oe});
    rdc(8'he7, 8'h32);
    chk("pin", 8'h01, {7'h0, port_power_pin});
    @(posedge ref_clk) port_power_reg <= 1'b0;
    repeat (2) step();
    chk("pin", 8'h00, {7'h0, port_power_pin});
    @(posedge ref_clk) port_power_reg <= 1'b1;
    repeat (2) step();
    chk("pin", 8'h01, {7'h0, port_power_pin});
    for (int i = 0; i < 40 && hub_stage !== 2'b01; i++) step();
    chk("stage", 8'h01, {6'h0, hub_stage});
    if (hub_stage !== 2'b01) give_verdict();
    repeat (30) step();
    chk("stage", 8'h01, {6'h0, hub_stage});
    $display("defaults done");
  endtask
  task automatic t_hold();
    do_reset();
    w(8'he7, 8'hff);
    repeat (30) step();
    chk("open", 8'h01, {7'h0, config_writes_open});
    rdc(8'he7, 8'h33);
    w(8'he7, 8'h30);
    #1 chk("stage", 8'h01, {6'h0, hub_stage});
    step();
    chk("stage", 8'h03, {6'h0, hub_stage});
    $display("hold done");
  endtask
  task automatic t_pins();
    w(8'he7, 8'h00);
    @(posedge ref_clk) overcurrent_reg <= 1'b1;
    repeat (3) step();
    chk("oe", 8'h00, {7'h0, port_power_pin_oe});
    chk("oc", 8'h01, {7'h0, overcurrent});
    w(8'he7, 8'h20);
    repeat (2) step();
    chk("oc", 8'h00, {7'h0, overcurrent});
    @(posedge ref_clk) overcurrent_sense_pin_n <= 1'b0;
    repeat (5) step();
    chk("oc", 8'h01, {7'h0, overcurrent});
    rdc(8'hea, 8'h00);
    $display("pins done");
  endtask
  task automatic t_events();
    w(8'he9, 8'hff);
    rdc(8'he9, 8'h1c);
    w(8'he9, 8'h00);
    pulse(4);
    chk("int", 8'h01, {7'h0, int_pin_n});
    w(8'he8, 8'hff);
    rdc(8'he8, 8'h10);
    w(8'he8, 8'h00);
    w(8'he9, 8'h1c);
    for (int k = 2; k < 5; k++) begin
      pulse(k);
      chk("int", 8'h00, {7'h0, int_pin_n});
      rdc(8'he8, 8'h80 | (8'h01 << k));
      w(8'he8, 8'h80);
      step();
      chk("int", 8'h00, {7'h0, int_pin_n});
      rdc(8'he8, 8'h80);
      w(8'he8, 8'h00);
      step();
      chk("int", 8'h01, {7'h0, int_pin_n});
    end
    $display("events done");
  endtask
  initial begin
    t_defaults();
    t_hold();
    t_pins();
    t_events();
    give_verdict();
  end
endmodule
bind hub_config_interlock_irq hub_cfg_checker hub_cfg_checker_i (.ref_clk, .rst, .reg_wr, .reg_rd, .reg_addr,
  .reg_wdata, .reg_rdata, .suspend_event, .host_configured_event, .port_power_event, .port_power_pin,
  .port_power_pin_oe, .int_pin_n, .hub_stage, .config_writes_open);
`default_nettype wire
